/* pmir_pkg.sv */
/*
  Package for the port mode and interrupt mask register group: register
  offsets, register layouts, reset values, mode codes and carrier structs.
  Assumes the management frame decoder delivers register-level requests.
*/
package pmir_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [4:0] REG_MEDIA_MODE = 5'h17;
  localparam logic [4:0] REG_EDGE_JUMBO = 5'h18;
  localparam logic [4:0] REG_INT_MASK   = 5'h19;
  localparam logic [4:0] REG_INT_STATUS = 5'h1A;

  // ==========================================================================
  // Register layouts
  typedef struct packed {
    logic [1:0] rsv_hi;        // 15:14 reserved, writable
    logic       rsv_13;        // 13 reserved, applied with the mode
    logic       mac_1000x;     // 12
    logic       prefer_copper; // 11
    logic [2:0] media_mode;    // 10:8
    logic [1:0] sense_override; // 7:6
    logic [1:0] rsv_54;        // read only zero
    logic       far_end_lb;    // 3
    logic [2:0] rsv_20;        // read only zero
  } pmir_media_reg_t;

  typedef struct packed {
    logic [2:0] edge_rate;     // 15:13
    logic       low_power;     // 12
    logic [5:0] rsv_116;       // read only zero
    logic [1:0] jumbo;         // 5:4
    logic [2:0] rsv_31;        // read only zero
    logic       connector_lb;  // 0
  } pmir_edge_reg_t;

  typedef struct packed {
    logic        pin_enable;   // 15
    logic [14:0] cause_mask;   // 14:0
  } pmir_mask_reg_t;

  localparam pmir_media_reg_t MEDIA_RESET = 16'h0000;
  localparam pmir_edge_reg_t  EDGE_RESET  = 16'h0000;
  localparam pmir_mask_reg_t  MASK_RESET  = 16'h0000;
  localparam logic [5:0]      PEND_RESET  = 6'h00;

  // ==========================================================================
  // Mode codes
  localparam logic [1:0] GLOBAL_MAC_PLAIN = 2'h0;
  localparam logic [2:0] MODE_COPPER      = 3'h0;
  localparam logic [2:0] MODE_SERDES      = 3'h1;
  localparam logic [2:0] MODE_1000X_AN    = 3'h2;
  localparam logic [2:0] MODE_100FX       = 3'h3;
  localparam logic [2:0] MODE_RESERVED    = 3'h4;
  localparam logic [1:0] OVR_NORMAL       = 2'h0;
  localparam logic [1:0] OVR_SERDES_ONLY  = 2'h1;
  localparam logic [1:0] OVR_COPPER_ONLY  = 2'h2;
  localparam logic [2:0] EDGE_RANK_XOR    = 3'h3;
  localparam logic [1:0] JUMBO_NORMAL     = 2'h0;
  localparam logic [1:0] JUMBO_MID        = 2'h1;
  localparam logic [1:0] JUMBO_LARGE      = 2'h2;

  // Packet length limits in bytes and reference clock offset limits in ppm
  localparam logic [14:0] LEN_NORMAL = 15'h0600;
  localparam logic [14:0] LEN_9K     = 15'h2400;
  localparam logic [14:0] LEN_12K    = 15'h3000;
  localparam logic [14:0] LEN_16K    = 15'h4000;
  localparam logic [6:0]  PPM_MID    = 7'h3C;
  localparam logic [6:0]  PPM_LARGE  = 7'h46;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [4:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } pmir_req_t;

  typedef struct packed {
    logic        mac_1000x;
    logic        mac_sel_valid;
    logic        prefer_copper;
    logic        copper_enable;
    logic        fiber_enable;
    logic [2:0]  fiber_kind;
    logic        auto_media_select;
    logic        far_end_lb;
    logic        connector_lb;
    logic [2:0]  edge_rank;
    logic [14:0] max_packet_len;
  } pmir_mode_t;

endpackage

/* pmir_regs.sv */
/*
  Per-port mode, edge rate, jumbo, loopback and interrupt mask registers,
  plus the read-to-clear interrupt status and the management interrupt pin.
  Assumes register requests, software reset, sticky reset enable and the
  interrupt events all come from logic on clk.
*/
// Summary of operation
// - Bit 12 picks SGMII or 1000BASE-X; valid only when global field is 00.
// - Bit 11 set prefers copper in media sensing, clear prefers fiber.
// - Bits 10:8 select copper, fiber kinds or automatic sensing; 100 reserved.
// - Bits 7:6 override sensing: normal, fiber only, copper only, reserved.
// - Written mode bits 13:8 only take effect at the next software reset.
// - Reading bits 13:8 shows the mode in effect, not the pending one.
// - Edge rate codes run slowest 011 down to fastest 100.
// - Bits 5:4 choose normal, 9 kB or 12 kB packet length limit.
// - Longer jumbo limits apply only with a tighter reference clock offset.
// - Mask bits 14:0 are sticky, reset to zero, enable their cause.
// - Mask bit 15 lets the interrupt pin follow the summary pending bit.
// - Clearing pin enable only blocks the pin; status keeps setting.
// - Masks work without the pin; the controller may poll status.
// - Mode bits 13:8 survive software reset whatever sticky enable says.
// - Sticky bits survive software reset only while sticky enable is set.
// - Status bits clear on read; bit 15 flags that an enabled (mask bit set) cause is pending.
`timescale 1ns/1ps

module pmir_regs
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Register requests from the management frame decoder
  input  wire pmir_pkg::pmir_req_t smi_req,
  output logic [15:0]             smi_rdata,
  output logic                    smi_rvalid,
  // Device controls
  input  wire logic               sw_reset,
  input  wire logic               sticky_reset_en,
  input  wire logic [1:0]         serdes_global_mode,
  input  wire logic [6:0]         ref_clk_ppm,
  // Interrupt sources
  input  wire logic [14:0]        int_event,
  // Mode outputs
  output pmir_pkg::pmir_mode_t    mode_out,
  // Open-drain management interrupt pin, active low
  output logic                    mgmt_interrupt_pin_out,
  output logic                    mgmt_interrupt_pin_oe_n
);

  // ==========================================================================
  // Helpers
  function automatic logic [14:0] jumbo_len(input logic [1:0] sel, input logic [6:0] ppm);
    logic [14:0] len;
    len = pmir_pkg::LEN_NORMAL;
    if (sel == pmir_pkg::JUMBO_MID)
      len = (ppm <= pmir_pkg::PPM_MID) ? pmir_pkg::LEN_12K : pmir_pkg::LEN_9K;
    else if (sel == pmir_pkg::JUMBO_LARGE)
      len = (ppm <= pmir_pkg::PPM_LARGE) ? pmir_pkg::LEN_16K : pmir_pkg::LEN_12K;
    return len;
  endfunction

  function automatic logic hit(input pmir_pkg::pmir_req_t r, input logic [4:0] a);
    return r.addr == a;
  endfunction

  // ==========================================================================
  // Register state
  pmir_pkg::pmir_media_reg_t media;
  pmir_pkg::pmir_media_reg_t next_media;
  pmir_pkg::pmir_edge_reg_t  edge_ctl;
  pmir_pkg::pmir_edge_reg_t  next_edge_ctl;
  pmir_pkg::pmir_mask_reg_t  mask;
  pmir_pkg::pmir_mask_reg_t  next_mask;
  logic [5:0]                pend;
  logic [5:0]                next_pend;
  logic [14:0]               status;
  logic [14:0]               next_status;
  logic [14:0]               read_clear;
  logic                      summary;

  assign summary = |(status & mask.cause_mask);

  always_comb
  begin
    next_media    = media;
    next_edge_ctl = edge_ctl;
    next_mask     = mask;
    next_pend     = pend;
    // Clear only what the read returned; a new event in the same cycle wins
    read_clear = (smi_req.rd && hit(smi_req, pmir_pkg::REG_INT_STATUS)) ? status : '0;
    next_status = (status & ~read_clear) | int_event;
    if (sw_reset)
    begin
      // Pending mode becomes the mode in effect; it is never cleared here
      {next_media.rsv_13, next_media.mac_1000x, next_media.prefer_copper,
       next_media.media_mode} = pend;
      next_media.rsv_hi       = pmir_pkg::MEDIA_RESET.rsv_hi;
      next_media.sense_override = pmir_pkg::MEDIA_RESET.sense_override;
      next_media.far_end_lb   = pmir_pkg::MEDIA_RESET.far_end_lb;
      next_edge_ctl.connector_lb = pmir_pkg::EDGE_RESET.connector_lb;
      if (!sticky_reset_en)
      begin
        next_edge_ctl = pmir_pkg::EDGE_RESET;
        next_mask     = pmir_pkg::MASK_RESET;
      end
    end
    else if (smi_req.wr && hit(smi_req, pmir_pkg::REG_MEDIA_MODE))
    begin
      next_pend               = smi_req.wdata[13:8];
      next_media.rsv_hi       = smi_req.wdata[15:14];
      next_media.sense_override = smi_req.wdata[7:6];
      next_media.far_end_lb   = smi_req.wdata[3];
    end
    else if (smi_req.wr && hit(smi_req, pmir_pkg::REG_EDGE_JUMBO))
    begin
      next_edge_ctl.edge_rate    = smi_req.wdata[15:13];
      next_edge_ctl.low_power    = smi_req.wdata[12];
      next_edge_ctl.jumbo        = smi_req.wdata[5:4];
      next_edge_ctl.connector_lb = smi_req.wdata[0];
    end
    else if (smi_req.wr && hit(smi_req, pmir_pkg::REG_INT_MASK))
    begin
      next_mask = smi_req.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      media    <= pmir_pkg::MEDIA_RESET;
      edge_ctl <= pmir_pkg::EDGE_RESET;
      mask     <= pmir_pkg::MASK_RESET;
      pend     <= pmir_pkg::PEND_RESET;
      status   <= '0;
    end
    else
    begin
      media    <= next_media;
      edge_ctl <= next_edge_ctl;
      mask     <= next_mask;
      pend     <= next_pend;
      status   <= next_status;
    end
  end

  // ==========================================================================
  // Read port, one cycle after the request
  logic [15:0] next_rdata;
  logic        next_rvalid;

  always_comb
  begin
    next_rvalid = smi_req.rd;
    next_rdata  = smi_rdata;
    // Read data holds until the next read
    if (!smi_req.rd)
      next_rdata = smi_rdata;
    else if (hit(smi_req, pmir_pkg::REG_MEDIA_MODE))
      next_rdata = media;
    else if (hit(smi_req, pmir_pkg::REG_EDGE_JUMBO))
      next_rdata = edge_ctl;
    else if (hit(smi_req, pmir_pkg::REG_INT_MASK))
      next_rdata = mask;
    else if (hit(smi_req, pmir_pkg::REG_INT_STATUS))
      next_rdata = {summary, status};
    else
      next_rdata = '0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      smi_rdata  <= '0;
      smi_rvalid <= 1'b0;
    end
    else
    begin
      smi_rdata  <= next_rdata;
      smi_rvalid <= next_rvalid;
    end
  end

  // ==========================================================================
  // Mode decode and interrupt pin
  pmir_pkg::pmir_mode_t next_mode;
  logic                 next_pin_oe_n;
  logic                 auto_sense;

  always_comb
  begin
    next_mode               = '0;
    auto_sense              = media.media_mode[2] && (media.media_mode != pmir_pkg::MODE_RESERVED);
    next_mode.mac_1000x     = media.mac_1000x;
    next_mode.mac_sel_valid = serdes_global_mode == pmir_pkg::GLOBAL_MAC_PLAIN;
    next_mode.prefer_copper = media.prefer_copper;
    next_mode.auto_media_select = auto_sense;
    // Fiber kind is one-hot: transfer, 1000BASE-X with autoneg, 100BASE-FX
    next_mode.fiber_kind = '0;
    if (media.media_mode[1:0] != pmir_pkg::MODE_COPPER[1:0] && media.media_mode != pmir_pkg::MODE_RESERVED)
      next_mode.fiber_kind[media.media_mode[1:0] - 2'h1] = 1'b1;
    next_mode.copper_enable = (media.media_mode == pmir_pkg::MODE_COPPER) || auto_sense;
    next_mode.fiber_enable  = |next_mode.fiber_kind;
    if (auto_sense && media.sense_override == pmir_pkg::OVR_SERDES_ONLY)
      next_mode.copper_enable = 1'b0;
    else if (auto_sense && media.sense_override == pmir_pkg::OVR_COPPER_ONLY)
      next_mode.fiber_enable = 1'b0;
    next_mode.far_end_lb     = media.far_end_lb;
    next_mode.connector_lb   = edge_ctl.connector_lb;
    next_mode.edge_rank      = edge_ctl.edge_rate ^ pmir_pkg::EDGE_RANK_XOR;
    next_mode.max_packet_len = jumbo_len(edge_ctl.jumbo, ref_clk_ppm);
    // Pin pulled low only while enabled and a masked cause is pending
    next_pin_oe_n = !(mask.pin_enable && summary);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_out                <= '0;
      mgmt_interrupt_pin_out  <= 1'b0;
      mgmt_interrupt_pin_oe_n <= 1'b1;
    end
    else
    begin
      mode_out                <= next_mode;
      mgmt_interrupt_pin_out  <= 1'b0;
      mgmt_interrupt_pin_oe_n <= next_pin_oe_n;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_pending_mode_hidden: assert property (
    (smi_req.wr && hit(smi_req, pmir_pkg::REG_MEDIA_MODE) && !sw_reset) |=>
      media.media_mode == $past(media.media_mode) && media.mac_1000x == $past(media.mac_1000x))
    else $error("mode changed without software reset");

  a_swreset_applies_mode: assert property (
    sw_reset |=> {media.rsv_13, media.mac_1000x, media.prefer_copper, media.media_mode} == $past(pend))
    else $error("software reset did not apply pending mode");

  a_sticky_kept: assert property (
    (sw_reset && sticky_reset_en) |=> mask == $past(mask) && edge_ctl.jumbo == $past(edge_ctl.jumbo))
    else $error("sticky bits lost with sticky enable set");

  a_sticky_cleared: assert property (
    (sw_reset && !sticky_reset_en) |=> mask == pmir_pkg::MASK_RESET && edge_ctl == pmir_pkg::EDGE_RESET)
    else $error("sticky bits kept with sticky enable clear");

  a_read_clears_status: assert property (
    (smi_req.rd && hit(smi_req, pmir_pkg::REG_INT_STATUS) && int_event == '0) |=> status == '0)
    else $error("status not cleared by read");

  a_event_set_wins: assert property (
    (int_event != '0) |=> (status & $past(int_event)) == $past(int_event))
    else $error("interrupt event lost");

  a_pin_follows_summary: assert property (
    (mask.pin_enable && summary) |=> !mgmt_interrupt_pin_oe_n ##1 !mgmt_interrupt_pin_out)
    else $error("pin not asserted for pending cause");

  a_pin_blocked: assert property (
    !mask.pin_enable |=> mgmt_interrupt_pin_oe_n)
    else $error("pin asserted while disabled");

  a_read_latency: assert property (
    (smi_req.rd && hit(smi_req, pmir_pkg::REG_MEDIA_MODE)) |=> smi_rvalid && smi_rdata == $past(media))
    else $error("media read wrong or late");

  a_edge_rank: assert property (
    (edge_ctl.edge_rate == 3'h4) |=> mode_out.edge_rank == 3'h7)
    else $error("fastest edge code not ranked fastest");

  c_mode_switch: cover property (smi_req.wr && hit(smi_req, pmir_pkg::REG_MEDIA_MODE) ##[1:20] sw_reset);
  c_pin_assert:  cover property (mask.pin_enable && summary ##1 !mgmt_interrupt_pin_oe_n);
  c_poll_clear:  cover property (summary && !mask.pin_enable ##1 smi_req.rd && hit(smi_req, pmir_pkg::REG_INT_STATUS));

endmodule

/* pmir_smc.sv */
/*
  Station management controller model: register reads, writes and the
  software reset pulse. Assumes requests are sampled on the rising clk edge.
*/
`timescale 1ns/1ps

module pmir_smc
(
  // Clock
  input  wire logic           clk,
  // Register port
  output pmir_pkg::pmir_req_t req,
  input  wire logic [15:0]    rdata,
  input  wire logic           rvalid,
  // Register 0 bit 15 write
  output logic                sw_reset
);
  initial req = '0;
  initial sw_reset = 1'b0;

  // ==========================================================================
  // Bus cycles
  // Released data is inverted so a stale value is never mistaken for live
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{a, 1'b1, 1'b0, d};
    @(posedge clk);
    req <= '{a, 1'b0, 1'b0, ~d};
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = '0;
    @(posedge clk);
    req <= '{a, 1'b0, 1'b1, 16'hFFFF};
    @(posedge clk);
    req.rd <= 1'b0;
    for (int n = 0; n < 4 && !ok; n++)
    begin
      @(negedge clk);
      if (rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = rdata;
      end
    end
  endtask

  // ==========================================================================
  // Controller sequences
  task automatic soft_reset;
    @(posedge clk);
    sw_reset <= 1'b1;
    @(posedge clk);
    sw_reset <= 1'b0;
  endtask

  // Stale causes cleared first so the pin does not fire on enable
  task automatic arm_pin(input logic [15:0] m);
    logic [15:0] d;
    logic        ok;
    rd(pmir_pkg::REG_INT_STATUS, d, ok);
    wr(pmir_pkg::REG_INT_MASK, m);
  endtask
endmodule

/* tb.sv */
/*
  Self-checking testbench for the port mode and interrupt mask registers.
  Assumes the controller model drives the register port and sw_reset.
*/
`timescale 1ns/1ps

module tb;
  logic                 clk;
  logic                 reset;
  pmir_pkg::pmir_req_t  smi_req;
  logic [15:0]          smi_rdata;
  logic                 smi_rvalid;
  logic                 sw_reset;
  logic                 sticky_reset_en;
  logic [1:0]           serdes_global_mode;
  logic [6:0]           ref_clk_ppm;
  logic [14:0]          int_event;
  pmir_pkg::pmir_mode_t mode_out;
  logic                 pin_out;
  logic                 pin_oe_n;
  int                   err_total;
  int                   checks_done;

  pmir_regs pmir_regs_i (.clk(clk), .reset(reset), .smi_req(smi_req), .smi_rdata(smi_rdata),
    .smi_rvalid(smi_rvalid), .sw_reset(sw_reset), .sticky_reset_en(sticky_reset_en),
    .serdes_global_mode(serdes_global_mode), .ref_clk_ppm(ref_clk_ppm), .int_event(int_event),
    .mode_out(mode_out), .mgmt_interrupt_pin_out(pin_out), .mgmt_interrupt_pin_oe_n(pin_oe_n));
  pmir_smc pmir_smc_i (.clk(clk), .req(smi_req), .rdata(smi_rdata), .rvalid(smi_rvalid),
    .sw_reset(sw_reset));

  // ==========================================================================
  // Helpers
  task automatic end_of_test;
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    pmir_smc_i.rd(a, d, ok);
    chk({15'h0, ok}, 16'h0001);
    if (!ok)
      end_of_test();
    else
      chk(d, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse(input logic [14:0] e);
    @(posedge clk);
    int_event <= e;
    @(posedge clk);
    int_event <= 15'h0000;
  endtask

  // Expected {copper, fiber, auto, kind} for a media code
  function automatic logic [5:0] media_exp(input logic [2:0] c);
    case (c)
      3'h0: return 6'b100000;
      3'h1: return 6'b010001;
      3'h2: return 6'b010010;
      3'h3: return 6'b010100;
      3'h4: return 6'b000000;
      3'h5: return 6'b111001;
      3'h6: return 6'b111010;
      default: return 6'b111100;
    endcase
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd_chk(5'h17, 16'h0000);
    rd_chk(5'h18, 16'h0000);
    rd_chk(5'h19, 16'h0000);
    rd_chk(5'h05, 16'h0000);
    chk({15'h0, pin_oe_n}, 16'h0001);
  endtask

  task automatic t_pending;
    pmir_smc_i.wr(5'h17, 16'h1E48);
    rd_chk(5'h17, 16'h0048);
    tick(2);
    chk({15'h0, mode_out.far_end_lb}, 16'h0001);
    pmir_smc_i.soft_reset();
    rd_chk(5'h17, 16'h1E00);
    tick(2);
    chk({13'h0, mode_out.mac_1000x, mode_out.mac_sel_valid, mode_out.prefer_copper}, 16'h0007);
    @(posedge clk);
    serdes_global_mode <= 2'h1;
    tick(3);
    chk({15'h0, mode_out.mac_sel_valid}, 16'h0000);
    serdes_global_mode <= 2'h0;
  endtask

  task automatic t_media;
    for (int c = 0; c < 8; c++)
    begin
      pmir_smc_i.wr(5'h17, {5'h00, c[2:0], 8'h00});
      pmir_smc_i.soft_reset();
      tick(3);
      chk({10'h0, mode_out.copper_enable, mode_out.fiber_enable, mode_out.auto_media_select,
        mode_out.fiber_kind}, {10'h0, media_exp(c[2:0])});
    end
    pmir_smc_i.wr(5'h17, 16'h0640);
    tick(3);
    chk({14'h0, mode_out.copper_enable, mode_out.fiber_enable}, 16'h0001);
    pmir_smc_i.wr(5'h17, 16'h0680);
    tick(3);
    chk({14'h0, mode_out.copper_enable, mode_out.fiber_enable}, 16'h0002);
    pmir_smc_i.wr(5'h17, 16'h0600);
  endtask

  task automatic t_edge;
    logic [15:0] d;
    logic [14:0] len [4] = '{15'h0600, 15'h2400, 15'h3000, 15'h0600};
    for (int i = 0; i < 8; i++)
    begin
      d = {i[2:0], 7'h00, i[1:0], 3'h0, i[0]};
      pmir_smc_i.wr(5'h18, d);
      rd_chk(5'h18, d);
      tick(2);
      chk({13'h0, mode_out.edge_rank}, {13'h0, i[2:0] ^ 3'h3});
      chk({1'b0, mode_out.max_packet_len}, {1'b0, len[i[1:0]]});
      chk({15'h0, mode_out.connector_lb}, {15'h0, i[0]});
    end
    ref_clk_ppm <= 7'h3C;
    pmir_smc_i.wr(5'h18, 16'h0010);
    tick(3);
    chk({1'b0, mode_out.max_packet_len}, 16'h3000);
    ref_clk_ppm <= 7'h46;
    pmir_smc_i.wr(5'h18, 16'h0020);
    tick(3);
    chk({1'b0, mode_out.max_packet_len}, 16'h4000);
  endtask

  task automatic t_sticky;
    pmir_smc_i.wr(5'h18, 16'hA011);
    pmir_smc_i.wr(5'h19, 16'h0003);
    pmir_smc_i.soft_reset();
    rd_chk(5'h18, 16'hA010);
    rd_chk(5'h19, 16'h0003);
    @(posedge clk);
    sticky_reset_en <= 1'b0;
    pmir_smc_i.soft_reset();
    rd_chk(5'h18, 16'h0000);
    rd_chk(5'h19, 16'h0000);
    rd_chk(5'h17, 16'h0600);
    @(posedge clk);
    sticky_reset_en <= 1'b1;
  endtask

  task automatic t_irq;
    pmir_smc_i.wr(5'h19, 16'h0001);
    pulse(15'h0001);
    rd_chk(5'h1A, 16'h8001);
    chk({15'h0, pin_oe_n}, 16'h0001);
    rd_chk(5'h1A, 16'h0000);
    pulse(15'h0020);
    rd_chk(5'h1A, 16'h0020);
    pmir_smc_i.wr(5'h1A, 16'hFFFF);
    rd_chk(5'h1A, 16'h0000);
    pulse(15'h0004);
    pmir_smc_i.arm_pin(16'h8004);
    tick(3);
    chk({15'h0, pin_oe_n}, 16'h0001);
    pulse(15'h0004);
    for (int n = 0; n < 4 && pin_oe_n !== 1'b0; n++)
      @(negedge clk);
    chk({14'h0, pin_oe_n, pin_out}, 16'h0000);
    if (pin_oe_n !== 1'b0)
      end_of_test();
    rd_chk(5'h1A, 16'h8004);
    tick(3);
    chk({15'h0, pin_oe_n}, 16'h0001);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    reset = 1'b1;
    sticky_reset_en = 1'b1;
    serdes_global_mode = 2'h0;
    ref_clk_ppm = 7'h64;
    int_event = 15'h0000;
    err_total = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_pending();
    t_media();
    t_edge();
    t_sticky();
    t_irq();
    end_of_test();
  end
endmodule
